/* sdm_handler.sv */
// Purpose: sensor-side handler for address change and M, C, MC, CC and D commands
// Assumes: received characters and break arrive as synchronous pulses from the link layer
// Notes: the measurement core supplies ttt, value count, completion and value characters
// Operation
// R1: address change command aAb! makes b the new address
// R2: address change is answered with new address, CR, LF
// R3: the logger keeps all addresses on one terminal distinct
// R4: the logger should attach one sensor only while changing an address
// R5: M is answered with address, three seconds digits, one count digit, CR LF
// R6: the seconds field states time until data is ready
// R7: a measurement reply is sent at once, before the measurement ends
// R8: after M completes, a service request of address, CR, LF is sent
// R9: after M the logger waits for service request, data or timeout
// R10: on a service request the logger sends D0 at once
// R11: D is answered at once with address, values, CR, LF
// R12: the logger scan interval should exceed the longest announced time
// R13: C is answered with address, three seconds digits, two count digits, CR LF
// R14: a concurrent measurement sends no service request
// R15: the logger sends D0 in the first scan after the time expires
// R16: the logger keeps running and may start other sensors meanwhile
// R17: the logger should scan at most every ten seconds with C
// R18: after MC or CC every data reply carries a CRC
// R19: the CRC is three characters placed just before CR LF
// R20: the logger checks the CRC on arrival and does not store it
// R21: every value starts with a plus or minus sign
// R22: data replies hold at most 35 characters after M, 75 after C
// R23: a break abandons a running M measurement
// R24: another valid command to this sensor aborts a running C measurement
// R25: both ends use the published CRC-16 and its three-character encoding
`timescale 1ns/10ps
`include "sdm_map.svh"
module sdm_handler import sdm_pkg::*; (
	input wire logic clk, // 50 MHz system clock
	input wire logic rst_n, // async reset, active low
	input wire logic [7:0] rx_char, // received command character
	input wire logic rx_valid, // one-cycle pulse per character
	input wire logic rx_break, // one-cycle pulse on a line break
	output logic [7:0] tx_char, // reply character to the link
	output logic tx_valid, // reply character offered
	input wire logic tx_ready, // link takes the character
	output logic [7:0] addr_now, // current sensor address
	output logic meas_start, // pulse: start a measurement
	output logic meas_conc, // started measurement is concurrent
	output logic [3:0] meas_param, // digit after M or C
	output logic meas_abort, // pulse: drop the running measurement
	input wire logic meas_done, // pulse: measurement finished
	input wire logic [11:0] meas_secs, // ttt as three BCD digits
	input wire logic [7:0] meas_count, // value count as two BCD digits
	output logic data_req, // pulse: supply values for a D command
	output logic [3:0] data_idx, // digit of the D command
	input wire logic [7:0] val_char, // value character
	input wire logic val_valid, // value character offered
	input wire logic val_first, // character opens a value
	input wire logic val_last, // last character of the reply
	output logic val_ready // value character taken
);
	logic [7:0] addr;
	logic pcmd, match;
	logic [7:0] body [4];
	logic [2:0] blen;
	logic cmd_end, seq_idle, take, crc_q;
	logic is_ack, is_chg, is_meas, is_data, is_c;
	logic [7:0] prm;
	logic run_m, run_c, crc_mode, data_conc, srq_pend, srq_go;
	sdm_seq_t st;
	sdm_rep_t rep;
	logic rep_conc, rep_crc;
	logic [1:0] idx;
	logic [11:0] lat_secs;
	logic [7:0] lat_cnt;
	logic [15:0] crc;
	logic [6:0] dcnt, limit;
	logic push, bin_ready, need_plus, val_sign, over, plus_sent;
	logic [7:0] ch;

	function automatic logic is_dig(input logic [7:0] c);
		return (c >= `SDM_CH_ZERO) && (c <= `SDM_CH_NINE);
	endfunction

	function automatic logic ok_addr(input logic [7:0] c);
		return is_dig(c) || (c >= `SDM_CH_UA && c <= `SDM_CH_UZ) ||
			(c >= `SDM_CH_LA && c <= `SDM_CH_LZ);
	endfunction

	// bitwise reflected CRC-16 over one character
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `SDM_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	// command framing: address, body up to four characters, terminator
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pcmd <= 1'b0;
			match <= 1'b0;
			blen <= 3'h0;
			for (int i = 0; i < 4; i++) begin
				body[i] <= 8'h00;
			end
		end else if (rx_break) begin
			pcmd <= 1'b0;
		end else if (rx_valid) begin
			if (!pcmd) begin
				pcmd <= 1'b1;
				match <= (rx_char == addr);
				blen <= 3'h0;
			end else if (rx_char == `SDM_CH_BANG) begin
				pcmd <= 1'b0;
			end else if (blen < `SDM_BODY_MAX) begin
				body[blen[1:0]] <= rx_char;
				blen <= blen + 3'h1;
			end else begin
				blen <= `SDM_BODY_BAD; // too long, never decodes
			end
		end
	end

	// decode; a command arriving while a reply is still going out is ignored
	assign cmd_end = rx_valid && !rx_break && pcmd && match && (rx_char == `SDM_CH_BANG);
	assign seq_idle = (st == SQ_IDLE);
	assign is_c = (body[0] == `SDM_CH_C);
	assign crc_q = (blen >= 3'h2) && (body[1] == `SDM_CH_C);
	assign prm = crc_q ? body[2] : body[1];
	assign is_ack = (blen == 3'h0);
	assign is_chg = (blen == 3'h2) && (body[0] == `SDM_CH_A) && ok_addr(body[1]);
	assign is_meas = ((body[0] == `SDM_CH_M) || is_c) &&
		((blen == (crc_q ? 3'h2 : 3'h1)) || ((blen == (crc_q ? 3'h3 : 3'h2)) && is_dig(prm)));
	assign is_data = (blen == 3'h2) && (body[0] == `SDM_CH_D) && is_dig(body[1]);
	assign take = cmd_end && seq_idle && (is_ack || is_chg || is_meas || is_data);
	assign srq_go = srq_pend && seq_idle && !take;

	// address register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr <= `SDM_ADDR_RST;
		end else if (take && is_chg) begin
			addr <= body[1]; // R1
		end
	end
	assign addr_now = addr;

	// measurement bookkeeping and core strobes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_m <= 1'b0;
			run_c <= 1'b0;
			crc_mode <= 1'b0;
			data_conc <= 1'b0;
			meas_start <= 1'b0;
			meas_abort <= 1'b0;
			meas_conc <= 1'b0;
			meas_param <= 4'h0;
			data_req <= 1'b0;
			data_idx <= 4'h0;
		end else begin
			meas_start <= take && is_meas;
			data_req <= take && is_data; // R11
			meas_abort <= (rx_break && run_m) || (take && run_c); // R23 R24
			if (take && is_data) begin
				data_idx <= body[1][3:0];
			end
			if (take && is_meas) begin
				run_m <= !is_c;
				run_c <= is_c;
				crc_mode <= crc_q; // R18
				data_conc <= is_c; // R22
				meas_conc <= is_c;
				meas_param <= (blen == (crc_q ? 3'h3 : 3'h2)) ? prm[3:0] : 4'h0;
			end else if ((rx_break && run_m) || meas_done || (take && run_c)) begin
				run_m <= 1'b0; // R23
				run_c <= 1'b0; // R24
			end
		end
	end

	// service request only for M; a new completion wins over the send
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			srq_pend <= 1'b0;
		end else if (meas_done && run_m && !(rx_break)) begin
			srq_pend <= 1'b1; // R8 R14
		end else if (srq_go || (take && is_meas)) begin
			srq_pend <= 1'b0;
		end
	end

	// reply character selection
	assign limit = data_conc ? `SDM_MAX_C : `SDM_MAX_M;
	assign over = (dcnt >= limit); // R22
	assign val_sign = (val_char == `SDM_CH_PLUS) || (val_char == `SDM_CH_MINUS);
	assign need_plus = val_first && !val_sign && !plus_sent; // R21

	// one inserted '+' per unsigned value; without the mark the same character would loop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			plus_sent <= 1'b0;
		end else if (take || val_ready) begin
			plus_sent <= 1'b0;
		end else if (st == SQ_VALS && need_plus && push && bin_ready) begin
			plus_sent <= 1'b1; // R21
		end
	end
	always_comb begin
		ch = `SDM_CH_CR;
		push = 1'b0;
		val_ready = 1'b0;
		case (st)
			SQ_ADDR: begin
				ch = addr;
				push = 1'b1;
			end
			SQ_TIME: begin
				ch = {`SDM_DIG_HI, lat_secs[4'(11 - 4 * idx) -: 4]}; // R6
				push = 1'b1;
			end
			SQ_CNT: begin
				ch = {`SDM_DIG_HI, idx[0] ? lat_cnt[3:0] : lat_cnt[7:4]};
				push = 1'b1;
			end
			SQ_VALS: begin
				ch = need_plus ? `SDM_CH_PLUS : val_char;
				push = val_valid && !over;
				val_ready = val_valid && (over || (bin_ready && !need_plus));
			end
			SQ_CRC: begin
				case (idx)
					2'h0: ch = {`SDM_CRC_TAG, 2'b00, crc[15:12]}; // R19 R25
					2'h1: ch = {`SDM_CRC_TAG, crc[11:6]};
					default: ch = {`SDM_CRC_TAG, crc[5:0]};
				endcase
				push = 1'b1;
			end
			SQ_CR: push = 1'b1;
			SQ_LF: begin
				ch = `SDM_CH_LF;
				push = 1'b1;
			end
			default: push = 1'b0;
		endcase
	end

	// reply sequencer, stalled by the buffer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= SQ_IDLE;
			rep <= RP_ADDR;
			rep_conc <= 1'b0;
			rep_crc <= 1'b0;
			idx <= 2'h0;
			lat_secs <= 12'h000;
			lat_cnt <= 8'h00;
		end else if (take) begin
			st <= SQ_ADDR; // R2 R5 R7 R11 R13
			rep <= is_meas ? RP_TIME : (is_data ? RP_DATA : RP_ADDR);
			rep_conc <= is_c; // R13
			rep_crc <= crc_mode;
			lat_secs <= meas_secs;
			lat_cnt <= meas_count;
			idx <= 2'h0;
		end else if (srq_go) begin
			st <= SQ_ADDR; // R8
			rep <= RP_ADDR;
		end else if (push && bin_ready) begin
			case (st)
				SQ_ADDR: st <= (rep == RP_TIME) ? SQ_TIME : ((rep == RP_DATA) ? SQ_VALS : SQ_CR);
				SQ_TIME: begin
					idx <= (idx == 2'h2) ? {1'b0, !rep_conc} : idx + 2'h1;
					if (idx == 2'h2) begin
						st <= SQ_CNT; // R5 R13
					end
				end
				SQ_CNT: begin
					idx <= 2'h0;
					if (idx == 2'h1) begin
						st <= SQ_CR;
					end else begin
						idx <= 2'h1;
					end
				end
				SQ_VALS: begin
					if (!need_plus && val_last) begin
						st <= rep_crc ? SQ_CRC : SQ_CR; // R18
					end
				end
				SQ_CRC: begin
					idx <= (idx == 2'h2) ? 2'h0 : idx + 2'h1;
					if (idx == 2'h2) begin
						st <= SQ_CR;
					end
				end
				SQ_CR: st <= SQ_LF;
				default: st <= SQ_IDLE;
			endcase
		end else if (st == SQ_VALS && val_valid && over && val_last) begin
			st <= rep_crc ? SQ_CRC : SQ_CR; // truncated tail still ends the reply
		end
	end

	// CRC over address and values; value character count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			crc <= `SDM_CRC_RST;
			dcnt <= 7'h00;
		end else if (take || srq_go) begin
			crc <= `SDM_CRC_RST;
			dcnt <= 7'h00;
		end else if (push && bin_ready && (st == SQ_ADDR || st == SQ_VALS)) begin
			crc <= crc_step(crc, ch); // R25
			if (st == SQ_VALS) begin
				dcnt <= dcnt + 7'h01;
			end
		end
	end

	sdm_buf #(.W(8), .D(2)) u_buf (
		.clk(clk),
		.rst_n(rst_n),
		.in_data(ch),
		.in_valid(push),
		.in_ready(bin_ready),
		.out_data(tx_char),
		.out_valid(tx_valid),
		.out_ready(tx_ready)
	);

	chg_addr_a: assert property (@(posedge clk) disable iff (!rst_n) // R1
		take && is_chg |=> addr == $past(body[1])) else $error("address not adopted");
	chg_reply_a: assert property (@(posedge clk) disable iff (!rst_n) // R2
		take && is_chg |=> st == SQ_ADDR && rep == RP_ADDR && ch == $past(body[1]))
		else $error("bad change reply");
	m_reply_a: assert property (@(posedge clk) disable iff (!rst_n) // R7
		take && is_meas |=> st == SQ_ADDR && rep == RP_TIME) else $error("no measure reply");
	ttt_digit_a: assert property (@(posedge clk) disable iff (!rst_n) // R6
		st == SQ_TIME && idx == 2'h0 |-> ch == {4'h3, lat_secs[11:8]}) else $error("bad ttt");
	srq_set_a: assert property (@(posedge clk) disable iff (!rst_n) // R8
		meas_done && run_m && !rx_break |=> srq_pend) else $error("service request lost");
	no_srq_a: assert property (@(posedge clk) disable iff (!rst_n) // R14
		meas_done && run_c && !srq_pend |=> !srq_pend) else $error("srq after C");
	crc_tail_a: assert property (@(posedge clk) disable iff (!rst_n) // R19
		st == SQ_CRC && push && bin_ready && idx == 2'h2 |=> st == SQ_CR) else $error("crc tail");
	value_sign_a: assert property (@(posedge clk) disable iff (!rst_n) // R21
		st == SQ_VALS && push && val_first && !plus_sent |-> ch == 8'h2B || ch == 8'h2D)
		else $error("no sign");
	data_limit_a: assert property (@(posedge clk) disable iff (!rst_n) // R22
		st == SQ_VALS && push |-> dcnt < (data_conc ? 7'h4B : 7'h23)) else $error("too long");
	break_stop_a: assert property (@(posedge clk) disable iff (!rst_n) // R23
		rx_break && run_m && !take |=> meas_abort && !run_m) else $error("break ignored");
	conc_abort_a: assert property (@(posedge clk) disable iff (!rst_n) // R24
		take && run_c |=> meas_abort) else $error("C not aborted");
endmodule

/* sdm_map.svh */
// Purpose: character codes, reset values and limits of the measure command handler
// Assumes: 8-bit ASCII characters on the command and reply streams
// Notes: definitions only
`ifndef SDM_MAP_SVH
`define SDM_MAP_SVH
`define SDM_ADDR_RST 8'h30
`define SDM_CH_CR 8'h0D
`define SDM_CH_LF 8'h0A
`define SDM_CH_BANG 8'h21
`define SDM_CH_PLUS 8'h2B
`define SDM_CH_MINUS 8'h2D
`define SDM_CH_ZERO 8'h30
`define SDM_CH_NINE 8'h39
`define SDM_CH_A 8'h41
`define SDM_CH_C 8'h43
`define SDM_CH_D 8'h44
`define SDM_CH_M 8'h4D
`define SDM_CH_UA 8'h41
`define SDM_CH_UZ 8'h5A
`define SDM_CH_LA 8'h61
`define SDM_CH_LZ 8'h7A
`define SDM_DIG_HI 4'h3
`define SDM_CRC_TAG 2'h1
`define SDM_CRC_POLY 16'hA001
`define SDM_CRC_RST 16'h0000
`define SDM_MAX_M 7'h23
`define SDM_MAX_C 7'h4B
`define SDM_BODY_MAX 3'h4
`define SDM_BODY_BAD 3'h5
`endif

/* sdm_pkg.sv */
// Purpose: shared types of the measure command handler
// Assumes: used together with sdm_map.svh
// Notes: states carry no fixed codes
package sdm_pkg;
	typedef enum logic [3:0] {
		SQ_IDLE, SQ_ADDR, SQ_TIME, SQ_CNT, SQ_VALS, SQ_CRC, SQ_CR, SQ_LF
	} sdm_seq_t;
	typedef enum logic [1:0] {RP_ADDR, RP_TIME, RP_DATA} sdm_rep_t;
endpackage

/* sdm_buf.sv */
// Purpose: two-entry valid/ready buffer in the reply character path
// Assumes: one clock, asynchronous active-low reset
// Notes: in_ready drops when full, so a stalled receiver loses no word
`timescale 1ns/10ps
module sdm_buf #(
	parameter int W = 8,
	parameter int D = 2
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic [W-1:0] in_data, // word to store
	input wire logic in_valid, // word offered
	output logic in_ready, // room for a word
	output logic [W-1:0] out_data, // oldest word
	output logic out_valid, // a word is held
	input wire logic out_ready // receiver takes the word
);
	localparam int PW = (D > 1) ? $clog2(D) : 1;
	localparam int CW = $clog2(D + 1);
	logic [W-1:0] mem [D];
	logic [PW-1:0] wp, rp;
	logic [CW-1:0] cnt;
	logic do_wr, do_rd;

	// honest full and empty from the fill count
	assign in_ready = (cnt != CW'(D));
	assign out_valid = (cnt != '0);
	assign out_data = mem[rp];
	assign do_wr = in_valid && in_ready;
	assign do_rd = out_valid && out_ready;

	// storage write and write pointer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp <= '0;
			for (int i = 0; i < D; i++) begin
				mem[i] <= '0;
			end
		end else if (do_wr) begin
			mem[wp] <= in_data;
			wp <= (wp == PW'(D - 1)) ? '0 : PW'(wp + 1'b1);
		end
	end

	// read pointer and fill count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rp <= '0;
			cnt <= '0;
		end else begin
			if (do_rd) begin
				rp <= (rp == PW'(D - 1)) ? '0 : PW'(rp + 1'b1);
			end
			if (do_wr && !do_rd) begin
				cnt <= CW'(cnt + 1'b1);
			end else if (do_rd && !do_wr) begin
				cnt <= CW'(cnt - 1'b1);
			end
		end
	end
endmodule

/* sdm_logger.sv */
// Purpose: behavioural bus controller facing the measure command handler
// Assumes: one character per rx_valid pulse, replies taken on tx_valid and tx_ready
// Notes: slow mode stalls every other cycle so the reply buffer must hold its words
`timescale 1ns/10ps
module sdm_logger (
	input wire logic clk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic [7:0] tx_char, // reply character
	input wire logic tx_valid, // reply character offered
	output logic tx_ready, // reply character accepted
	output logic [7:0] rx_char, // command character
	output logic rx_valid // command character strobe
);
	logic [7:0] q[$];
	bit slow;
	// quiet line at time zero
	initial begin
		rx_char = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
	end
	// ready toggles in slow mode to stall the sensor
	always @(posedge clk) begin
		tx_ready <= rst_n && (slow ? ~tx_ready : 1'b1);
	end
	// raw capture, crc characters are judged by the bench
	always @(posedge clk) begin
		if (rst_n && tx_valid && tx_ready) q.push_back(tx_char);
	end
	// one sensor on the terminal, one command at a time after the last reply
	task automatic send(string c);
		foreach (c[i]) begin
			@(posedge clk);
			rx_char <= c[i];
			rx_valid <= 1'b1;
			@(posedge clk);
			rx_valid <= 1'b0;
			rx_char <= ~c[i]; // released line must not keep the last value
		end
	endtask
endmodule

/* tb_sdm_measure_command_handler.sv */
// Purpose: self-checking bench for the measure command handler
// Assumes: bench plays the measurement core, sdm_logger plays the controller
// Notes: expected replies and crc are built here from the character rules
`timescale 1ns/10ps
`include "sdm_map.svh"
module tb_sdm_measure_command_handler;
	localparam int CYC_MAX = 20000;
	logic clk, rst_n, rx_valid, rx_break, tx_valid, tx_ready, meas_start, meas_conc;
	logic meas_abort, meas_done, data_req, val_valid, val_first, val_last, val_ready;
	logic [7:0] rx_char, tx_char, addr_now, meas_count, val_char;
	logic [11:0] meas_secs;
	logic [3:0] meas_param, data_idx;
	int error_cnt, cmp_count, cyc, n_start, n_abort, vi;
	string vs, crlf;
	bit vact;
	sdm_logger lg (.clk(clk), .rst_n(rst_n), .tx_char(tx_char), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx_char(rx_char), .rx_valid(rx_valid));
	sdm_handler dut (.clk(clk), .rst_n(rst_n), .rx_char(rx_char), .rx_valid(rx_valid),
		.rx_break(rx_break), .tx_char(tx_char), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.addr_now(addr_now), .meas_start(meas_start), .meas_conc(meas_conc),
		.meas_param(meas_param), .meas_abort(meas_abort), .meas_done(meas_done),
		.meas_secs(meas_secs), .meas_count(meas_count), .data_req(data_req),
		.data_idx(data_idx), .val_char(val_char), .val_valid(val_valid),
		.val_first(val_first), .val_last(val_last), .val_ready(val_ready));
	// value stream of the core, one string per data request
	assign val_valid = vact;
	assign val_char = vact ? vs[vi] : 8'h00;
	assign val_first = vact && (vi == 0 || vs[vi] == `SDM_CH_PLUS || vs[vi] == `SDM_CH_MINUS);
	assign val_last = vact && (vi == vs.len() - 1);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// core side: values follow data_req, pulses are counted for the checks
	always @(posedge clk) begin
		if (data_req) begin
			vi <= 0;
			vact <= 1'b1;
		end else if (vact && val_ready) begin
			if (vi == vs.len() - 1) vact <= 1'b0;
			else vi <= vi + 1;
		end
		if (meas_start) n_start <= n_start + 1;
		if (meas_abort) n_abort <= n_abort + 1;
	end
	// hang guard: the whole run needs a few hundred cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == CYC_MAX) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: timeout", $time);
			conclude();
		end
	end
	task automatic chk8(logic [7:0] g, logic [7:0] e, string m);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic chk_n(int g, int e, string m);
		cmp_count++;
		if (g != e) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s got %0d exp %0d", $time, m, g, e);
		end
	endtask
	// waits a bounded time for a whole reply, then compares it character by character
	task automatic expect_str(string e, string m);
		int k;
		k = 0;
		while (lg.q.size() < e.len() && k < 3000) begin
			@(posedge clk);
			k++;
		end
		chk_n(lg.q.size(), e.len(), m);
		foreach (e[i]) if (lg.q.size() > 0) chk8(lg.q.pop_front(), e[i], m);
	endtask
	task automatic quiet(string m);
		repeat (60) @(posedge clk);
		chk_n(lg.q.size(), 0, m);
	endtask
	task automatic pulse_done();
		@(posedge clk) meas_done <= 1'b1;
		@(posedge clk) meas_done <= 1'b0;
	endtask
	function automatic string crc3(string s);
		logic [15:0] c;
		c = `SDM_CRC_RST;
		foreach (s[i]) begin
			c = c ^ {8'h00, s[i]};
			repeat (8) c = c[0] ? ((c >> 1) ^ `SDM_CRC_POLY) : (c >> 1);
		end
		return $sformatf("%c%c%c", 8'h40 | c[15:12], 8'h40 | c[11:6], 8'h40 | c[5:0]);
	endfunction
	task automatic t_addr();
		chk8(addr_now, `SDM_ADDR_RST, "reset address");
		lg.send("0A2!");
		expect_str({"2", crlf}, "address reply");
		chk8(addr_now, 8'h32, "new address");
		lg.send("0M!");
		quiet("old address ignored");
		$display("test addr done, mismatches %0d", error_cnt);
	endtask
	// slow controller stalls the reply buffer throughout
	task automatic t_meas();
		int s;
		s = n_start;
		lg.slow = 1'b1;
		lg.send("2M3!");
		expect_str({"20352", crlf}, "M reply");
		chk_n(n_start - s, 1, "M start");
		chk8({4'h0, meas_param}, 8'h03, "M digit");
		chk8({7'h00, meas_conc}, 8'h00, "M not concurrent");
		pulse_done();
		expect_str({"2", crlf}, "service request");
		vs = "+.859+3.54";
		lg.send("2D0!");
		expect_str({"2+.859+3.54", crlf}, "D reply");
		lg.slow = 1'b0;
		$display("test meas done, mismatches %0d", error_cnt);
	endtask
	task automatic t_conc();
		meas_secs <= 12'h030;
		meas_count <= 8'h05;
		lg.send("2C!");
		expect_str({"203005", crlf}, "C reply");
		chk8({7'h00, meas_conc}, 8'h01, "C concurrent");
		pulse_done();
		quiet("no service request");
		vs = "1+2";
		lg.send("2D0!");
		expect_str({"2+1+2", crlf}, "sign inserted");
		lg.send("2CC!");
		expect_str({"203005", crlf}, "CC reply");
		pulse_done();
		vs = "+1";
		lg.send("2D4!");
		expect_str({"2+1", crc3("2+1"), crlf}, "crc reply");
		chk8({4'h0, data_idx}, 8'h04, "D digit");
		lg.send("2MC1!");
		expect_str({"20305", crlf}, "MC reply");
		chk8({4'h0, meas_param}, 8'h01, "MC digit");
		pulse_done();
		expect_str({"2", crlf}, "MC service request");
		$display("test conc done, mismatches %0d", error_cnt);
	endtask
	task automatic t_abort();
		int s;
		s = n_abort;
		lg.send("2C!");
		expect_str({"203005", crlf}, "C reply");
		lg.send("2!");
		expect_str({"2", crlf}, "ack reply");
		chk_n(n_abort - s, 1, "C aborted");
		meas_secs <= 12'h035;
		meas_count <= 8'h02;
		s = n_abort;
		lg.send("2M!");
		expect_str({"20352", crlf}, "M reply");
		@(posedge clk) rx_break <= 1'b1;
		@(posedge clk) rx_break <= 1'b0;
		repeat (4) @(posedge clk);
		chk_n(n_abort - s, 1, "break abort");
		vs = "+";
		repeat (39) vs = {vs, "7"};
		lg.send("2D1!");
		expect_str({"2", vs.substr(0, 34), crlf}, "data limit");
		quiet("nothing after limit");
		$display("test abort done, mismatches %0d", error_cnt);
	endtask
	task automatic conclude();
		$display("compares %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		rst_n = 1'b0;
		rx_break = 1'b0;
		meas_done = 1'b0;
		meas_secs = 12'h035;
		meas_count = 8'h02;
		crlf = "\015\012";
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_addr();
		t_meas();
		t_conc();
		t_abort();
		conclude();
	end
endmodule
